// >>> src/dcc_channel.sv
/*
 One DMA channel: control, address and count registers, the soft reset
 sequencer and a read-then-write bus master.
 Assumes a same-clock register port and a bus slave that answers each
 request with a one-cycle ack; the peripheral request comes from logic on clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_channel #(
	parameter int SRST_CYCLES = `DCC_SRST_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// register port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	// peripheral request
	input wire logic periph_req_in,
	// bus master
	output logic bm_req_out,
	output logic bm_write_out,
	output logic [31:0] bm_addr_out,
	output logic [1:0] bm_size_out,
	output logic [31:0] bm_wdata_out,
	input wire logic bm_ack_in,
	input wire logic [31:0] bm_rdata_in,
	// status
	output logic busy_out,
	output logic buf_full_out
);
	initial begin
		if (SRST_CYCLES < 1 || SRST_CYCLES > 3)
			$error("SRST_CYCLES must be 1 to 3");
	end

	dcc_pkg::dcc_regs_t r_q;
	dcc_pkg::dcc_regs_t r_d;
	logic buf_load;
	logic buf_unload;
	logic buf_clear;
	logic [1:0] op_size;
	logic [31:0] op_bytes;

	// size of one operation
	always_comb begin
		op_size = `DCC_SIZE_WORD;
		if (r_q.mode != `DCC_MODE_M2M) begin
			case (r_q.width)
				`DCC_WID_BYTE: op_size = `DCC_SIZE_BYTE;
				`DCC_WID_HALF: op_size = `DCC_SIZE_HALF;
				default: op_size = `DCC_SIZE_WORD;
			endcase
		end
		op_bytes = 32'h0000_0001 << op_size;
	end

	always_comb begin
		r_d = r_q;
		buf_load = 1'b0;
		buf_unload = 1'b0;
		buf_clear = 1'b0;
		r_d.rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`DCC_OFS_CTRL: begin
					r_d.rdata[`DCC_BIT_EN] = r_q.en;
					r_d.rdata[`DCC_BIT_SRST] = r_q.srst;
					r_d.rdata[`DCC_POS_MODE +: 2] = r_q.mode;
					r_d.rdata[`DCC_POS_SSTEP +: 2] = r_q.sstep;
					r_d.rdata[`DCC_POS_DSTEP +: 2] = r_q.dstep;
					r_d.rdata[`DCC_POS_WIDTH +: 2] = r_q.width;
					r_d.rdata[`DCC_BIT_TRIG] = r_q.trig;
				end
				`DCC_OFS_SRC: r_d.rdata = r_q.sar;
				`DCC_OFS_DST: r_d.rdata = r_q.dar;
				`DCC_OFS_COUNT: r_d.rdata = {16'h0000, r_q.bcr};
				`DCC_OFS_CUR_SRC: r_d.rdata = r_q.csar;
				`DCC_OFS_CUR_DST: r_d.rdata = r_q.cdar;
				`DCC_OFS_CUR_COUNT: r_d.rdata = {16'h0000, r_q.cbcr};
				default: r_d.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_wr_in) begin
			case (reg_addr_in)
				`DCC_OFS_CTRL: begin
					r_d.en = reg_wdata_in[`DCC_BIT_EN];
					r_d.mode = reg_wdata_in[`DCC_POS_MODE +: 2];
					r_d.sstep = reg_wdata_in[`DCC_POS_SSTEP +: 2];
					r_d.dstep = reg_wdata_in[`DCC_POS_DSTEP +: 2];
					r_d.width = reg_wdata_in[`DCC_POS_WIDTH +: 2];
					if (reg_wdata_in[`DCC_BIT_TRIG])
						r_d.trig = 1'b1;
					if (reg_wdata_in[`DCC_BIT_SRST]) begin
						r_d.srst = 1'b1;
						r_d.srst_cnt = 2'(SRST_CYCLES);
					end
				end
				`DCC_OFS_SRC: r_d.sar = reg_wdata_in;
				`DCC_OFS_DST: r_d.dar = reg_wdata_in;
				`DCC_OFS_COUNT: r_d.bcr = reg_wdata_in[15:0];
				default: ;
			endcase
		end

		case (r_q.st)
			dcc_pkg::DCC_IDLE: begin
				if (r_q.en && r_q.trig) begin
					r_d.csar = r_q.sar;
					r_d.cdar = r_q.dar;
					r_d.cbcr = r_q.bcr;
					r_d.st = dcc_pkg::DCC_RUN;
				end
			end
			dcc_pkg::DCC_RUN: begin
				if (r_q.cbcr == 16'h0000) begin
					r_d.trig = 1'b0;
					r_d.st = dcc_pkg::DCC_IDLE;
				end else if (r_q.mode == `DCC_MODE_M2M || periph_req_in) begin
					r_d.bm_req = 1'b1;
					r_d.bm_write = 1'b0;
					r_d.bm_addr = r_q.csar;
					r_d.bm_size = op_size;
					r_d.st = dcc_pkg::DCC_RD;
				end
			end
			dcc_pkg::DCC_RD: begin
				if (bm_ack_in) begin
					buf_load = 1'b1;
					r_d.bm_write = 1'b1;
					r_d.bm_addr = r_q.cdar;
					r_d.st = dcc_pkg::DCC_WR;
				end
			end
			dcc_pkg::DCC_WR: begin
				if (bm_ack_in) begin
					buf_unload = 1'b1;
					r_d.bm_req = 1'b0;
					r_d.bm_write = 1'b0;
					if (r_q.sstep == `DCC_STEP_INC)
						r_d.csar = r_q.csar + op_bytes;
					if (r_q.dstep == `DCC_STEP_INC)
						r_d.cdar = r_q.cdar + op_bytes;
					if ({16'h0000, r_q.cbcr} <= op_bytes)
						r_d.cbcr = 16'h0000;
					else
						r_d.cbcr = r_q.cbcr - op_bytes[15:0];
					r_d.st = dcc_pkg::DCC_RUN;
				end
			end
			default: r_d.st = dcc_pkg::DCC_IDLE;
		endcase

		// soft reset engine: settings stay, enable and trigger drop
		if (r_q.srst) begin
			if (r_q.srst_cnt <= 2'h1)
				r_d.srst = 1'b0;
			r_d.srst_cnt = r_q.srst_cnt - 2'h1;
		end
		if (r_d.srst) begin
			r_d.en = 1'b0;
			r_d.trig = 1'b0;
			r_d.st = dcc_pkg::DCC_IDLE;
			buf_clear = 1'b1;
		end
		if (!r_d.en) begin
			r_d.st = dcc_pkg::DCC_IDLE;
			r_d.bm_req = 1'b0;
			r_d.bm_write = 1'b0;
			buf_clear = 1'b1;
		end
		// busy is kept in its own flop so the output needs no decode
		r_d.busy = (r_d.st != dcc_pkg::DCC_IDLE);
		if (reset_in) begin
			r_d = '0;
			r_d.st = dcc_pkg::DCC_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		r_q <= r_d;
	end

	dcc_xfer_buf #(
		.WIDTH(32)
	) u_buf (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(buf_clear),
		.load_in(buf_load),
		.unload_in(buf_unload),
		.data_in(bm_rdata_in),
		.data_out(bm_wdata_out),
		.full_out(buf_full_out)
	);

	assign reg_rdata_out = r_q.rdata;
	assign bm_req_out = r_q.bm_req;
	assign bm_write_out = r_q.bm_write;
	assign bm_addr_out = r_q.bm_addr;
	assign bm_size_out = r_q.bm_size;
	assign busy_out = r_q.busy;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	AST_SRST_SELFCLR: assert property ($rose(r_q.srst) |-> ##[1:3] !r_q.srst)
		else $error("soft reset bit did not clear itself");
	AST_SRST_DROPS_EN: assert property (r_q.srst |-> !r_q.en && !r_q.trig)
		else $error("enable survived a soft reset");
	AST_SRST_KEEPS_CFG: assert property (r_q.srst && !reg_wr_in |=> $stable(r_q.mode)
		&& $stable(r_q.width) && $stable(r_q.sstep) && $stable(r_q.dstep))
		else $error("soft reset changed control settings");
	AST_SRST_IDLE: assert property (r_q.srst |-> r_q.st == dcc_pkg::DCC_IDLE && !buf_full_out)
		else $error("soft reset left engine busy");
	AST_ZERO_NO_SRST: assert property (!r_q.srst && reg_wr_in && reg_addr_in == `DCC_OFS_CTRL
		&& !reg_wdata_in[`DCC_BIT_SRST] |=> !r_q.srst)
		else $error("zero write started a soft reset");
	AST_DIS_IDLE: assert property (!r_q.en |-> !bm_req_out && r_q.st == dcc_pkg::DCC_IDLE)
		else $error("bus master active while disabled");
	AST_EN_NEEDED: assert property ($rose(bm_req_out) |-> $past(r_q.en))
		else $error("request issued without enable");
	AST_M2M_WORD: assert property (bm_req_out && r_q.mode == `DCC_MODE_M2M
		|-> bm_size_out == `DCC_SIZE_WORD)
		else $error("memory mode not moving words");
	AST_P2M_BYTE: assert property ($rose(bm_req_out) && r_q.mode != `DCC_MODE_M2M
		&& r_q.width == `DCC_WID_BYTE |-> bm_size_out == `DCC_SIZE_BYTE)
		else $error("byte width not honoured");
	AST_SRC_STEP: assert property (r_q.st == dcc_pkg::DCC_WR && bm_ack_in && r_d.en
		|=> r_q.csar == $past(r_q.csar) + ($past(r_q.sstep) == `DCC_STEP_INC
		? (32'h0000_0001 << $past(bm_size_out)) : 32'h0000_0000))
		else $error("source address stepped wrongly");
	AST_DST_FIXED: assert property (r_q.st == dcc_pkg::DCC_WR && bm_ack_in
		&& r_q.dstep == `DCC_STEP_FIX |=> $stable(r_q.cdar))
		else $error("fixed destination moved");
	AST_DONE_CLEARS: assert property (r_q.st == dcc_pkg::DCC_RUN && r_q.cbcr == 16'h0000
		&& !r_q.srst |=> !r_q.trig && r_q.st == dcc_pkg::DCC_IDLE)
		else $error("trigger not cleared at end");

	COV_M2M_OP: cover property (r_q.mode == `DCC_MODE_M2M && r_q.st == dcc_pkg::DCC_WR && bm_ack_in);
	COV_P2M_OP: cover property (r_q.mode == `DCC_MODE_P2M && $rose(bm_req_out));
	COV_DONE: cover property ($fell(r_q.trig) && !r_q.srst);
	COV_SRST_BUSY: cover property (r_q.st != dcc_pkg::DCC_IDLE ##1 r_q.srst);
	COV_M2P_OP: cover property (r_q.mode == `DCC_MODE_M2P && $rose(bm_req_out));

	// register port checks
	AST_SRC_READBACK: assert property (reg_wr_in && reg_addr_in == `DCC_OFS_SRC
		|=> r_q.sar == $past(reg_wdata_in))
		else $error("source address write lost");
	AST_RDATA_IDLE_ZERO: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
		else $error("read data not zero outside a read");
	AST_SRST_WRITE_STARTS: assert property (reg_wr_in && reg_addr_in == `DCC_OFS_CTRL
		&& reg_wdata_in[`DCC_BIT_SRST] |=> r_q.srst)
		else $error("soft reset write ignored");

	// operation size checks in the peripheral modes
	AST_P2M_HALF: assert property ($rose(bm_req_out) && r_q.mode != `DCC_MODE_M2M
		&& r_q.width == `DCC_WID_HALF |-> bm_size_out == `DCC_SIZE_HALF)
		else $error("half-word width not honoured");
	AST_P2M_WORD: assert property ($rose(bm_req_out) && r_q.mode != `DCC_MODE_M2M
		&& r_q.width == `DCC_WID_WORD |-> bm_size_out == `DCC_SIZE_WORD)
		else $error("word width not honoured");

	// address and count stepping at the end of each operation
	AST_DST_STEP: assert property (r_q.st == dcc_pkg::DCC_WR && bm_ack_in && r_d.en
		&& r_q.dstep == `DCC_STEP_INC
		|=> r_q.cdar == $past(r_q.cdar) + (32'h0000_0001 << $past(bm_size_out)))
		else $error("destination address stepped wrongly");
	AST_SRC_FIXED: assert property (r_q.st == dcc_pkg::DCC_WR && bm_ack_in
		&& r_q.sstep == `DCC_STEP_FIX |=> $stable(r_q.csar))
		else $error("fixed source moved");
	AST_COUNT_DOWN: assert property (r_q.st == dcc_pkg::DCC_WR && bm_ack_in && r_d.en
		|=> r_q.cbcr < $past(r_q.cbcr))
		else $error("remaining count did not fall");

	// the engine leaves idle only on an enabled trigger
	AST_START_NEEDS_TRIG: assert property ($rose(busy_out) |-> $past(r_q.trig)
		&& $past(r_q.en))
		else $error("engine started without trigger");
	AST_BUSY_MATCHES_STATE: assert property (busy_out == (r_q.st != dcc_pkg::DCC_IDLE))
		else $error("busy flag out of step with engine");
endmodule // dcc_channel
`default_nettype wire

// >>> src/dcc_params.svh
/*
 Constants of the channel control block: register offsets, field positions,
 reset values, field codes and the soft reset length.
 Assumes a byte-addressed register port with one 32-bit word per register.
*/
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

`define DCC_OFS_CTRL 8'h00
`define DCC_OFS_SRC 8'h04
`define DCC_OFS_DST 8'h08
`define DCC_OFS_COUNT 8'h0C
`define DCC_OFS_CUR_SRC 8'h14
`define DCC_OFS_CUR_DST 8'h18
`define DCC_OFS_CUR_COUNT 8'h1C

`define DCC_BIT_EN 0
`define DCC_BIT_SRST 1
`define DCC_POS_MODE 2
`define DCC_POS_SSTEP 4
`define DCC_POS_DSTEP 6
`define DCC_POS_WIDTH 19
`define DCC_BIT_TRIG 23

`define DCC_RST_WORD 32'h0000_0000

`define DCC_MODE_M2M 2'h0
`define DCC_MODE_P2M 2'h1
`define DCC_MODE_M2P 2'h2
`define DCC_WID_WORD 2'h0
`define DCC_WID_BYTE 2'h1
`define DCC_WID_HALF 2'h2
`define DCC_STEP_INC 2'h0
`define DCC_STEP_FIX 2'h2

`define DCC_SIZE_BYTE 2'h0
`define DCC_SIZE_HALF 2'h1
`define DCC_SIZE_WORD 2'h2

`define DCC_SRST_CYCLES 2

`endif

// >>> src/dcc_pkg.sv
/*
 Types of the channel control block: state encoding and state records.
 Assumes dcc_params.svh is on the include path.
*/
`include "dcc_params.svh"
package dcc_pkg;
	typedef enum logic [3:0] {
		DCC_IDLE = 4'h1,
		DCC_RUN = 4'h2,
		DCC_RD = 4'h4,
		DCC_WR = 4'h8
	} dcc_state_t;

	typedef struct packed {
		logic en;
		logic srst;
		logic trig;
		logic [1:0] mode;
		logic [1:0] width;
		logic [1:0] dstep;
		logic [1:0] sstep;
		logic [31:0] sar;
		logic [31:0] dar;
		logic [15:0] bcr;
		logic [31:0] csar;
		logic [31:0] cdar;
		logic [15:0] cbcr;
		logic [1:0] srst_cnt;
		dcc_state_t st;
		logic busy;
		logic bm_req;
		logic bm_write;
		logic [31:0] bm_addr;
		logic [1:0] bm_size;
		logic [31:0] rdata;
	} dcc_regs_t;

	typedef struct packed {
		logic [31:0] data;
		logic full;
	} dcc_buf_t;
endpackage

// >>> src/dcc_xfer_buf.sv
/*
 One-word transfer buffer between the read and the write of an operation.
 Assumes load and unload never coincide and clear wins over both.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_xfer_buf #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// control
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic unload_in,
	input wire logic [31:0] data_in,
	// state
	output logic [31:0] data_out,
	output logic full_out
);
	initial begin
		if (WIDTH != 32)
			$error("dcc_xfer_buf serves only a 32-bit word");
	end

	dcc_pkg::dcc_buf_t b_q;
	dcc_pkg::dcc_buf_t b_d;

	always_comb begin
		b_d = b_q;
		if (load_in) begin
			b_d.data = data_in;
			b_d.full = 1'b1;
		end
		if (unload_in)
			b_d.full = 1'b0;
		if (clear_in || reset_in) begin
			b_d = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		b_q <= b_d;
	end

	assign data_out = b_q.data;
	assign full_out = b_q.full;
endmodule // dcc_xfer_buf
`default_nettype wire

// >>> sim/dcc_bus_slave.sv
/*
 Bus slave model for the channel's master port.
 Assumes each request is held until a one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_bus_slave (
	// clock
	input wire logic clk_in,
	// bus
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [31:0] addr_in,
	input wire logic [3:0] dly_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [3:0] wait_q = 4'h0;
	logic [31:0] cyc_q = 32'h0;
	// ack after dly_in wait cycles
	assign ack_out = req_in && (wait_q == dly_in);
	// data only with a read ack, a moving pattern otherwise
	assign rdata_out = (ack_out && !write_in) ? {addr_in[15:0], ~addr_in[15:0]} : ~cyc_q;
	always_ff @(posedge clk_in) begin
		cyc_q <= cyc_q + 32'h1;
		wait_q <= (req_in && !ack_out) ? wait_q + 4'h1 : 4'h0;
	end
endmodule // dcc_bus_slave
`default_nettype wire

// >>> sim/dcc_channel_tb.sv
/*
 Self-checking bench of one channel.
 Assumes dcc_params.svh on the include path and the slave model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_channel_tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic periph_req_in = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [31:0] reg_rdata_out, bm_addr_out, bm_wdata_out, bm_rdata_in;
	logic bm_req_out, bm_write_out, bm_ack_in, busy_out, buf_full_out;
	logic [1:0] bm_size_out;
	logic [66:0] log_q[$];
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int req_cycles = 0;
	always #50 clk_in = ~clk_in;
	dcc_channel #(.SRST_CYCLES(2)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.periph_req_in(periph_req_in), .bm_req_out(bm_req_out),
		.bm_write_out(bm_write_out), .bm_addr_out(bm_addr_out),
		.bm_size_out(bm_size_out), .bm_wdata_out(bm_wdata_out), .bm_ack_in(bm_ack_in),
		.bm_rdata_in(bm_rdata_in), .busy_out(busy_out), .buf_full_out(buf_full_out));
	dcc_bus_slave partner (.clk_in(clk_in), .req_in(bm_req_out), .write_in(bm_write_out),
		.addr_in(bm_addr_out), .dly_in(dly), .ack_out(bm_ack_in), .rdata_out(bm_rdata_in));
	// log every acked bus phase
	always @(posedge clk_in) begin
		cycles++;
		if (bm_req_out === 1'b1) req_cycles++;
		if (bm_req_out === 1'b1 && bm_ack_in === 1'b1) begin
			log_q.push_back({bm_write_out, bm_size_out, bm_addr_out,
				bm_write_out ? bm_wdata_out : bm_rdata_in});
		end
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic results;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_in);
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		chk(reg_rdata_out, e);
	endtask
	task automatic wait_idle;
		int i;
		repeat (3) @(negedge clk_in);
		for (i = 0; i < 300 && busy_out !== 1'b0; i++) @(negedge clk_in);
		chk({31'h0, busy_out}, 32'h0);
	endtask
	// program, run and check n operations
	task automatic run(input logic [31:0] ctl, input logic [15:0] cnt, input logic [1:0] sz,
		input logic [31:0] sb, input logic [31:0] db, input logic [31:0] n);
		logic [66:0] e;
		logic [31:0] k;
		log_q.delete();
		wr(`DCC_OFS_SRC, 32'h0000_1000);
		wr(`DCC_OFS_DST, 32'h0000_2000);
		wr(`DCC_OFS_COUNT, {16'h0, cnt});
		wr(`DCC_OFS_CTRL, ctl);
		wait_idle();
		chk(32'(log_q.size()), 2 * n);
		for (k = 0; k < n && log_q.size() >= 2; k++) begin
			e = log_q.pop_front();
			chk({29'h0, e[66:64]}, {30'h0, sz});
			chk({29'h0, log_q[0][66:64]}, {29'h0, 1'b1, sz});
			chk(e[63:32], 32'h1000 + k * sb);
			chk(log_q[0][63:32], 32'h2000 + k * db);
			chk(log_q[0][31:0], e[31:0]);
			void'(log_q.pop_front());
		end
		rd(`DCC_OFS_CUR_COUNT, 32'h0);
		rd(`DCC_OFS_CUR_SRC, 32'h1000 + n * sb);
		rd(`DCC_OFS_CUR_DST, 32'h2000 + n * db);
		rd(`DCC_OFS_CTRL, ctl & ~32'h0080_0000);
	endtask
	initial begin
		int i;
		repeat (6) @(negedge clk_in);
		reset_in = 1'b0;
		periph_req_in = 1'b1;
		for (i = 0; i < 8; i++) rd(8'(4 * i), `DCC_RST_WORD);
		wr(`DCC_OFS_SRC, 32'h89AB_CDE4);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0);
		rd(`DCC_OFS_SRC, 32'h89AB_CDE4);
		wr(`DCC_OFS_COUNT, 32'hFFFF_0010);
		rd(`DCC_OFS_COUNT, 32'h0000_0010);
		wr(`DCC_OFS_DST, 32'h1234_5678);
		rd(`DCC_OFS_DST, 32'h1234_5678);
		$display("test registers done");
		run(32'h0088_0001, 16'h0008, 2'h2, 4, 4, 2);
		run(32'h0088_0025, 16'h0002, 2'h0, 0, 1, 2);
		run(32'h0090_0089, 16'h0004, 2'h1, 2, 0, 2);
		dly = 4'h3;
		run(32'h0080_0005, 16'h0008, 2'h2, 4, 4, 2);
		$display("test transfers done");
		wr(`DCC_OFS_CTRL, 32'h0080_0004);
		req_cycles = 0;
		repeat (20) @(negedge clk_in);
		chk(32'(req_cycles), 32'h0);
		chk({31'h0, busy_out}, 32'h0);
		$display("test disabled done");
		dly = 4'hF;
		wr(`DCC_OFS_COUNT, 32'h0000_0008);
		wr(`DCC_OFS_CTRL, 32'h0090_00A1);
		for (i = 0; i < 100 && buf_full_out !== 1'b1; i++) @(negedge clk_in);
		chk({31'h0, buf_full_out}, 32'h1);
		wr(`DCC_OFS_CTRL, 32'h0010_00A3);
		repeat (2) @(negedge clk_in);
		chk({29'h0, bm_req_out, busy_out, buf_full_out}, 32'h0);
		repeat (3) @(negedge clk_in);
		rd(`DCC_OFS_CTRL, 32'h0010_00A0);
		dly = 4'h0;
		run(32'h0080_0001, 16'h0004, 2'h2, 4, 4, 1);
		$display("test soft reset done");
		results();
	end
endmodule // dcc_channel_tb
`default_nettype wire
